// >>> verilog/bt_host_power_handshake.sv
// Host power handshake and radio power-down control for the baseband core
// Behaviour
// - Separate tx, rx, pll and pa power-down outputs, each independent.
// - Device wake active only when enabled and host transport is in UART mode; disabled host wake is held low and clock request is ungated.
// - Asserted device wake keeps the device awake for as long as it stays asserted.
// - Deasserted wake allows sleep only once sleep criteria also hold.
// - Device wake and host wake polarities are each software selectable.
// - Clock request asserts when Bluetooth or WLAN needs the reference clock.
// - Clock request is fixed active high.
// - Pad function select for the three handshake pins stays at zero.
// - Power actions come from software registers or baseband packet handling.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
module bt_host_power_handshake (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [pwr_hs_pkg::ADDR_W-1:0] ADDR,
	input wire logic [pwr_hs_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [pwr_hs_pkg::DATA_W-1:0] RDATA,
	input wire logic DEVICE_WAKE_IN,
	output logic HOST_WAKE_OUT,
	output logic CLK_REQ_OUT,
	input wire logic BT_CLK_NEED,
	input wire logic WLAN_CLK_NEED,
	input wire logic SLEEP_CRITERIA_MET,
	input wire logic [pwr_hs_pkg::RF_N-1:0] PKT_RF_ON,
	input wire logic PKT_HOST_REQ,
	output logic DEVICE_AWAKE,
	output logic [pwr_hs_pkg::RF_N-1:0] RF_PWRDN,
	output logic [3:0] PAD_FUNC_SEL
);
	import pwr_hs_pkg::*;

	typedef enum logic [0:0] {
		ST_SLEEP,
		ST_WAKE
	} pwr_e;

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [RF_N-1:0] rfpd;
		pwr_e pst;
		logic host_wake;
		logic clk_req;
		logic [RF_N-1:0] rf_out;
		logic [3:0] pad;
		logic [DATA_W-1:0] rdata;
	} state_s;

	state_s st_q;
	state_s st_d;

	// Synchronised wake pin and the decoded handshake terms
	logic wake_sync;
	logic wake_level;
	logic wake_act;
	logic hs_on;
	logic host_req;
	logic host_level;
	logic sleep_allowed;

	// Radio and status terms shared by the state and read paths
	logic asleep;
	logic [RF_N-1:0] rf_next;
	logic [DATA_W-1:0] status_word;

	// The pin is asynchronous to the baseband clock, so nothing reads it before two flops
	pwr_sync2 u_wake_sync (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.d(DEVICE_WAKE_IN),
		.q(wake_sync)
	);

	// Wake handshake lines only carry meaning in UART transport with the option enabled
	assign hs_on = st_q.ctrl[CTRL_HS_EN] & st_q.ctrl[CTRL_UART_MODE];

	// Polarity bit set means the pin is asserted high
	assign wake_level = wake_sync ~^ st_q.ctrl[CTRL_DW_POL];
	assign wake_act = hs_on & wake_level;

	// Software and packet handling may each ask for the host
	assign host_req = st_q.ctrl[CTRL_HOST_REQ] | PKT_HOST_REQ;

	// Pin level for the host wake line; idle is the inverse of the asserted level
	assign host_level = (hs_on & host_req) ~^ st_q.ctrl[CTRL_HW_POL];

	// Sleep needs software consent and the criteria; a dropped wake pin is not enough
	assign sleep_allowed = ~wake_act & st_q.ctrl[CTRL_SLEEP_OK] & SLEEP_CRITERIA_MET;

	assign asleep = (st_q.pst == ST_SLEEP);

	// One power-down term per radio block; packets can only switch a block on
	for (genvar g = 0; g < RF_N; g++) begin : g_rf
		assign rf_next[g] = asleep | (st_q.rfpd[g] & ~PKT_RF_ON[g]);
	end : g_rf

	// Status snapshot; the read path copies it only on a read strobe
	always_comb begin
		status_word = RD_ZERO;
		status_word[ST_AWAKE] = ~asleep;
		status_word[ST_WAKE_IN] = wake_act;
		status_word[ST_HOST_WAKE] = st_q.host_wake;
		status_word[ST_CLK_REQ] = st_q.clk_req;
		status_word[ST_RF_PD +: RF_N] = st_q.rf_out;
	end

	always_comb begin
		st_d = st_q;

		// Register writes; status and pad select are read only
		if (WR) begin
			unique case (ADDR)
				REG_CTRL: begin
					st_d.ctrl = WDATA[CTRL_W-1:0];
				end
				REG_RFPD: begin
					st_d.rfpd = WDATA[RF_N-1:0];
				end
				default: begin
				end
			endcase
		end

		// Sleep state machine
		unique case (st_q.pst)
			ST_SLEEP: begin
				if (!sleep_allowed) begin
					st_d.pst = ST_WAKE;
				end
			end
			ST_WAKE: begin
				// Wake dropping alone never forces sleep
				if (sleep_allowed) begin
					st_d.pst = ST_SLEEP;
				end
			end
		endcase

		// Held low while disabled, which is also its reset level
		st_d.host_wake = host_level & hs_on;

		// Fixed active high request for the reference clock
		st_d.clk_req = BT_CLK_NEED | WLAN_CLK_NEED;

		// Asleep forces every radio block down regardless of software or packets
		st_d.rf_out = rf_next;

		st_d.pad = PADSEL_HS;

		// Read data stands only in the cycle after the read strobe
		st_d.rdata = RD_ZERO;
		if (RD) begin
			unique case (ADDR)
				REG_CTRL: begin
					st_d.rdata[CTRL_W-1:0] = st_q.ctrl;
				end
				REG_RFPD: begin
					st_d.rdata[RF_N-1:0] = st_q.rfpd;
				end
				REG_STATUS: begin
					st_d.rdata = status_word;
				end
				REG_PADSEL: begin
					st_d.rdata[3:0] = st_q.pad;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q.ctrl <= CTRL_RST;
			st_q.rfpd <= RFPD_RST;
			st_q.pst <= ST_WAKE;
			st_q.host_wake <= 1'b0;
			st_q.clk_req <= 1'b0;
			st_q.rf_out <= RFPD_RST;
			st_q.pad <= PADSEL_HS;
			st_q.rdata <= RD_ZERO;
		end else begin
			st_q <= st_d;
		end
	end

	assign RDATA = st_q.rdata;
	assign HOST_WAKE_OUT = st_q.host_wake;
	assign CLK_REQ_OUT = st_q.clk_req;
	assign DEVICE_AWAKE = (st_q.pst == ST_WAKE);
	assign RF_PWRDN = st_q.rf_out;
	assign PAD_FUNC_SEL = st_q.pad;
endmodule : bt_host_power_handshake

// >>> common/pwr_hs_pkg.sv
// Package with constants and encodings for the host power handshake block
package pwr_hs_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	// Register indices (byte address is four times the index)
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_RFPD = 4'h1;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h2;
	localparam logic [ADDR_W-1:0] REG_PADSEL = 4'h3;
	// Control register fields
	localparam int CTRL_HS_EN = 0;
	localparam int CTRL_DW_POL = 1;
	localparam int CTRL_HW_POL = 2;
	localparam int CTRL_HOST_REQ = 3;
	localparam int CTRL_SLEEP_OK = 4;
	localparam int CTRL_UART_MODE = 5;
	localparam int CTRL_W = 6;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
	// RF power-down field order: tx, rx, pll, pa
	localparam int RF_N = 4;
	localparam logic [RF_N-1:0] RFPD_RST = 4'hf;
	// Status fields
	localparam int ST_AWAKE = 0;
	localparam int ST_WAKE_IN = 1;
	localparam int ST_HOST_WAKE = 2;
	localparam int ST_CLK_REQ = 3;
	localparam int ST_RF_PD = 4;
	// Pad function value that selects the handshake function
	localparam logic [3:0] PADSEL_HS = 4'h0;
	localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
endpackage : pwr_hs_pkg

// >>> verilog/pwr_sync2.sv
// Two-stage synchroniser for an asynchronous level input
`timescale 1ns/1ps
module pwr_sync2 (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	typedef struct packed {
		logic s1;
		logic s2;
	} sync_s;
	sync_s st_q;
	sync_s st_d;
	always_comb begin
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign q = st_q.s2;
endmodule : pwr_sync2

// >>> tb/pwr_hs_assertions.sv
// Port checker for the host power handshake block
`timescale 1ns/1ps
module pwr_hs_chk (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic WR,
	input wire logic DEVICE_WAKE_IN,
	input wire logic HOST_WAKE_OUT,
	input wire logic CLK_REQ_OUT,
	input wire logic BT_CLK_NEED,
	input wire logic WLAN_CLK_NEED,
	input wire logic SLEEP_CRITERIA_MET,
	input wire logic [pwr_hs_pkg::RF_N-1:0] PKT_RF_ON,
	input wire logic PKT_HOST_REQ,
	input wire logic DEVICE_AWAKE,
	input wire logic [pwr_hs_pkg::RF_N-1:0] RF_PWRDN,
	input wire logic [3:0] PAD_FUNC_SEL
);
	import pwr_hs_pkg::*;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	chk_pad_sel_zero: assert property (PAD_FUNC_SEL == PADSEL_HS)
		else $error("pad select not zero");
	chk_clk_req_follow: assert property ($past(RST_N) |->
		CLK_REQ_OUT == $past(BT_CLK_NEED | WLAN_CLK_NEED)) else $error("clock request wrong");
	chk_rf_sleep_off: assert property ($past(RST_N) && !$past(DEVICE_AWAKE) |->
		RF_PWRDN == 4'hf) else $error("radio on while asleep");
	chk_rf_pkt_on: assert property ($past(RST_N) && $past(DEVICE_AWAKE) |->
		(RF_PWRDN & $past(PKT_RF_ON)) == 4'h0) else $error("packet request ignored");
	chk_sleep_cause: assert property ($fell(DEVICE_AWAKE) |->
		$past(SLEEP_CRITERIA_MET)) else $error("slept without criteria");
	chk_wake_cause: assert property ($rose(DEVICE_AWAKE) && $past(SLEEP_CRITERIA_MET) &&
		!$past(WR, 2) |-> $past(DEVICE_WAKE_IN, 3) != $past(DEVICE_WAKE_IN, 4))
		else $error("woke without pin");
	chk_reset_idle: assert property ($rose(RST_N) |->
		!HOST_WAKE_OUT && !CLK_REQ_OUT) else $error("outputs active after reset");
	chk_host_wake_cause: assert property ($changed(HOST_WAKE_OUT) |->
		$past(WR, 2) || $past(PKT_HOST_REQ) != $past(PKT_HOST_REQ, 2)) else $error("host wake moved");
endmodule : pwr_hs_chk

// >>> tb/host_model.sv
// Host processor model: drives device wake, reacts to host wake
`timescale 1ns/1ps
module host_model (
	input wire logic clk,
	input wire logic want,
	input wire logic pol,
	input wire logic host_wake,
	input wire logic hw_pol,
	output logic dev_wake = 1'b0,
	output logic host_up
);
	// Pin moves one edge after the host decides, like a real GPIO write
	always @(posedge clk) dev_wake <= want ~^ pol;
	assign host_up = host_wake ~^ hw_pol;
endmodule : host_model

// >>> tb/tb.sv
// Testbench for the host power handshake block
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("BAD %s exp %h got %h", n, e, a); end end
module tb;
	import pwr_hs_pkg::*;
	logic SYS_CLK = 0, RST_N = 0, WR = 0, RD = 0, bt = 0, wl = 0, crit = 0, hreq = 0;
	logic want = 0, wp = 1, hp = 1, dw, hw, cr, awake, up;
	logic [3:0] ADDR = 0, pkt = 0, rfpd, pad;
	logic [31:0] WDATA = 0, RDATA;
	int miscompares = 0, n_checks = 0;
	always #25 SYS_CLK = ~SYS_CLK;
	bt_host_power_handshake u_bt_host_power_handshake (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .DEVICE_WAKE_IN(dw),
		.HOST_WAKE_OUT(hw), .CLK_REQ_OUT(cr), .BT_CLK_NEED(bt), .WLAN_CLK_NEED(wl),
		.SLEEP_CRITERIA_MET(crit), .PKT_RF_ON(pkt), .PKT_HOST_REQ(hreq),
		.DEVICE_AWAKE(awake), .RF_PWRDN(rfpd), .PAD_FUNC_SEL(pad));
	host_model u_host_model (.clk(SYS_CLK), .want(want), .pol(wp), .host_wake(hw),
		.hw_pol(hp), .dev_wake(dw), .host_up(up));
	task automatic tick(input int n);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask : tick
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge SYS_CLK) begin ADDR <= a; WDATA <= d; WR <= 1; end
		@(posedge SYS_CLK) WR <= 0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge SYS_CLK) begin ADDR <= a; RD <= 1; end
		@(posedge SYS_CLK) RD <= 0;
		#1 `CHK("rdata", e, RDATA)
	endtask : rd
	task automatic t_regs;
		`CHK("idle", 2'b00, {hw, cr})
		rd(REG_CTRL, 0);
		rd(REG_RFPD, 32'hf);
		wr(REG_PADSEL, 32'h5);
		rd(REG_PADSEL, 0);
		`CHK("pad", 4'h0, pad)
		rd(4'h9, 0);
	endtask : t_regs
	task automatic t_clk;
		bt <= 1;
		tick(1);
		`CHK("bt_req", 1'b1, cr)
		bt <= 0;
		wl <= 1;
		tick(1);
		`CHK("wl_req", 1'b1, cr)
		wl <= 0;
		tick(1);
		`CHK("no_req", 1'b0, cr)
	endtask : t_clk
	task automatic t_host;
		wr(REG_CTRL, 32'h25);
		hreq <= 1;
		tick(2);
		`CHK("pkt_hw", 2'b11, {hw, up})
		hreq <= 0;
		hp <= 0;
		wr(REG_CTRL, 32'h21);
		tick(1);
		`CHK("low_idle", 2'b10, {hw, up})
		wr(REG_CTRL, 32'h29);
		tick(1);
		`CHK("low_act", 2'b01, {hw, up})
		wr(REG_CTRL, 32'h01);
		tick(1);
		`CHK("no_uart", 2'b01, {hw, up})
	endtask : t_host
	task automatic t_sleep;
		wr(REG_CTRL, 32'h33);
		tick(3);
		`CHK("no_crit", 1'b1, awake)
		crit <= 1;
		tick(2);
		`CHK("sleep", 5'h0f, {awake, rfpd})
		want <= 1;
		tick(4);
		`CHK("wake", 1'b1, awake)
		pkt <= 4'h5;
		tick(4);
		`CHK("stay", 5'h1a, {awake, rfpd})
		rd(REG_STATUS, 32'h0000_00a7);
		wp <= 0;
		wr(REG_CTRL, 32'h31);
		want <= 0;
		tick(6);
		`CHK("low_pol", 1'b0, awake)
	endtask : t_sleep
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : finish_test
	initial begin
		repeat (5) @(posedge SYS_CLK);
		RST_N <= 1;
		t_regs;
		t_clk;
		t_host;
		t_sleep;
		finish_test;
	end
	initial begin
		#100000;
		miscompares++;
		finish_test;
	end
endmodule : tb
bind bt_host_power_handshake pwr_hs_chk u_pwr_hs_chk (.*);
